// file: hdl/rup_map.vh
// constants for the remote upgrade user port
`ifndef RUP_MAP_VH
`define RUP_MAP_VH
`define RUP_SR_W 32
`define RUP_SR_MSB 31
`define RUP_CTRL_OVR_BIT 0
`define RUP_CTRL_IMG_BIT 1
`define RUP_CTRL_RST 32'h00000000
`define RUP_STAT_RST 32'h00000000
`define RUP_MODE_W 2
`define RUP_STAT_MODE_LSB 0
`define RUP_STAT_MODE_MSB 1
`define RUP_STAT_FORCED_BIT 2
`define RUP_STAT_LOADED_BIT 3
`define RUP_KICK_IDLE 1'b1
`define RUP_REQ_IDLE 1'b0
`define RUP_CLK_NS 100
`define RUP_KICK_MIN_NS 250
`define RUP_KICK_CYC ((`RUP_KICK_MIN_NS + `RUP_CLK_NS - 1) / `RUP_CLK_NS)
`define RUP_CNT_W 3
`endif

// file: hdl/rup_sync.v
// two flip-flop synchroniser for one level
module rup_sync (
  // clock and reset
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_rst_val,
  // level
  input wire i_d,
  output wire o_q
);
  reg meta;
  reg sync;
  // reset value is a constant picked by the parent through a tie, XORed onto the output after the flops
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= 1'b0;
      sync <= 1'b0;
    end else begin
      meta <= i_d;
      sync <= meta;
    end
  end
  assign o_q = sync ^ i_rst_val;
endmodule

// file: hdl/rup_port.v
// core-side serial port of the remote upgrade unit
// ----------------------------------------
// Notes on behaviour
// ----------------------------------------
// Notes on behaviour
// RULE1: every load and shift happens on the rising clock edge only.
// RULE2: shift high moves one bit out to serial output, one in from serial input.
// RULE3: capture high reads mode into shift register; low writes control registers.
// RULE4: user logic presents each bit on serial input; taken at rising edge.
// RULE5: falling edge on watchdog kick resets the user watchdog.
// RULE6: user logic holds watchdog kick low at least 250 ns.
// RULE7: rising reconfiguration request starts a device reconfiguration.
// RULE8: serial output is the shift register output bit, updated each edge.
// RULE9: shift low captures status or updates control, chosen by capture input.
// RULE10: after image 0 loads in forced mode, override bit selects next image.
`include "rup_map.vh"
module rup_port (
  // clock and reset
  input wire i_sys_clk,
  input wire i_rst,
  // serial port from user logic
  input wire i_shift,
  input wire i_capture,
  input wire i_serial_in,
  input wire i_watchdog_kick_n,
  input wire i_reconfig_req,
  // status from the configuration section
  input wire [`RUP_MODE_W-1:0] i_config_mode,
  input wire i_forced_img0,
  input wire i_img0_loaded,
  // serial data back to user logic
  output reg o_serial_out,
  // actions toward the configuration section
  output reg o_watchdog_reset,
  output reg o_reconfig_start,
  output reg o_next_image,
  output reg [`RUP_SR_W-1:0] o_ctrl
);

  // ----------------------------------------
  // control decode
  // ----------------------------------------
  reg do_shift;
  reg do_capture;
  reg do_update;
  // RULE3 RULE9 shift wins; otherwise the capture input picks the load source
  always @* begin
    do_shift = 1'b0;
    do_capture = 1'b0;
    do_update = 1'b0;
    case ({i_shift, i_capture})
      2'h0: begin
        do_update = 1'b1;
      end
      2'h1: begin
        do_capture = 1'b1;
      end
      default: begin
        do_shift = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire kick_n_s;
  wire reconfig_s;
  // kick idles high, so its synchroniser reads high out of reset
  rup_sync u_sync_kick (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_rst_val(`RUP_KICK_IDLE),
    .i_d(~i_watchdog_kick_n),
    .o_q(kick_n_s)
  );
  // a request shorter than one clock period may be missed
  rup_sync u_sync_cfg (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_rst_val(`RUP_REQ_IDLE),
    .i_d(i_reconfig_req),
    .o_q(reconfig_s)
  );

  // ----------------------------------------
  // status word
  // ----------------------------------------
  reg [`RUP_SR_W-1:0] status_word;
  // unused upper bits read back as zero
  always @* begin
    status_word = `RUP_STAT_RST;
    status_word[`RUP_STAT_MODE_MSB:`RUP_STAT_MODE_LSB] = i_config_mode;
    status_word[`RUP_STAT_FORCED_BIT] = i_forced_img0;
    status_word[`RUP_STAT_LOADED_BIT] = i_img0_loaded;
  end

  // ----------------------------------------
  // serial shift register
  // ----------------------------------------
  reg [`RUP_SR_W-1:0] shreg;
  reg [`RUP_SR_W-1:0] next_shreg;
  always @* begin
    next_shreg = shreg;
    if (do_shift) begin
      // RULE2 RULE4 msb leaves, serial input enters at bit 0
      next_shreg = {shreg[`RUP_SR_MSB-1:0], i_serial_in};
    end else if (do_capture) begin
      // RULE9 parallel capture of status
      next_shreg = status_word;
    end
  end

  // RULE1 rising edge only
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      shreg <= `RUP_STAT_RST;
    end else begin
      shreg <= next_shreg;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  reg [`RUP_SR_W-1:0] next_ctrl;
  always @* begin
    next_ctrl = o_ctrl;
    if (do_update) begin
      // RULE3 RULE9 shift register written into control
      next_ctrl = shreg;
    end
  end

  // RULE1 rising edge only
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ctrl <= `RUP_CTRL_RST;
    end else begin
      o_ctrl <= next_ctrl;
    end
  end

  // ----------------------------------------
  // serial output
  // ----------------------------------------
  // RULE8 registered new msb, so the pin never follows the control inputs directly
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_serial_out <= 1'b0;
    end else begin
      o_serial_out <= next_shreg[`RUP_SR_MSB];
    end
  end

  // ----------------------------------------
  // image select override
  // ----------------------------------------
  wire override_ok;
  reg next_img_sel;
  // RULE10 override only once image 0 has loaded in forced mode
  assign override_ok = i_forced_img0 & i_img0_loaded & o_ctrl[`RUP_CTRL_OVR_BIT];
  always @* begin
    next_img_sel = o_next_image;
    if (override_ok) begin
      next_img_sel = o_ctrl[`RUP_CTRL_IMG_BIT];
    end
  end

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_next_image <= 1'b0;
    end else begin
      o_next_image <= next_img_sel;
    end
  end

  // ----------------------------------------
  // watchdog kick
  // ----------------------------------------
  reg kick_d;
  wire kick_fall;
  // RULE5 falling edge of the synchronised kick
  assign kick_fall = kick_d & ~kick_n_s;
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      kick_d <= `RUP_KICK_IDLE;
    end else begin
      kick_d <= kick_n_s;
    end
  end

  // pulse is one clock wide, three edges after the pin falls
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_watchdog_reset <= 1'b0;
    end else begin
      o_watchdog_reset <= kick_fall;
    end
  end

  // ----------------------------------------
  // reconfiguration request
  // ----------------------------------------
  reg cfg_d;
  wire cfg_rise;
  // RULE7 rising edge of the synchronised request
  assign cfg_rise = reconfig_s & ~cfg_d;
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_d <= `RUP_REQ_IDLE;
    end else begin
      cfg_d <= reconfig_s;
    end
  end

  // pulse is one clock wide, three edges after the pin rises
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reconfig_start <= 1'b0;
    end else begin
      o_reconfig_start <= cfg_rise;
    end
  end
endmodule

// file: verif/rup_port_props.sv
// assertions on the remote upgrade user port
`include "rup_map.vh"
module rup_port_props (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_shift,
  input wire i_capture,
  input wire i_watchdog_kick_n,
  input wire i_reconfig_req,
  input wire o_serial_out,
  input wire o_watchdog_reset,
  input wire o_reconfig_start,
  input wire [`RUP_SR_W-1:0] o_ctrl
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  capture_out_a: assert property (!i_shift && i_capture |=> !o_serial_out)
    else $error("capture out");
  kick_pulse_a: assert property ($fell(i_watchdog_kick_n) |-> ##[2:3] o_watchdog_reset)
    else $error("kick pulse");
  kick_once_a: assert property (o_watchdog_reset |=> !o_watchdog_reset)
    else $error("kick long");
  kick_cause_a: assert property (o_watchdog_reset |-> $past(!i_watchdog_kick_n, 2))
    else $error("kick cause");
  req_pulse_a: assert property ($rose(i_reconfig_req) |-> ##[2:3] o_reconfig_start)
    else $error("req pulse");
  req_once_a: assert property (o_reconfig_start |=> !o_reconfig_start)
    else $error("req long");
  req_cause_a: assert property (o_reconfig_start |-> $past(i_reconfig_req, 2))
    else $error("req cause");
  ctrl_hold_a: assert property (i_shift || i_capture |=> $stable(o_ctrl))
    else $error("ctrl moved");
endmodule
bind rup_port rup_port_props i_props (.i_sys_clk, .i_rst, .i_shift, .i_capture,
  .i_watchdog_kick_n, .i_reconfig_req, .o_serial_out, .o_watchdog_reset,
  .o_reconfig_start, .o_ctrl);

// file: verif/rup_user.sv
// user-logic model driving watchdog kick and reconfiguration request
module rup_user (
  input wire logic i_sys_clk,
  input wire logic i_kick,
  input wire logic i_req,
  output logic o_watchdog_kick_n = 1'b1,
  output logic o_reconfig_req = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] low = 2'h0;
  always @(posedge i_sys_clk) begin
    low <= i_kick ? 2'h3 : low - (low != 2'h0);
    o_watchdog_kick_n <= !(i_kick || low > 2'h1);
    o_reconfig_req <= i_req;
  end
endmodule

// file: verif/rup_port_tb.sv
// testbench for the remote upgrade user port
`include "rup_map.vh"
module rup_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_shift = 1'b0, i_capture = 1'b1, i_serial_in = 1'b0;
  logic kick = 1'b0, req = 1'b0, kick_n, rq, o_serial_out, o_watchdog_reset, o_reconfig_start;
  logic o_next_image, forced = 1'b1, loaded = 1'b1;
  logic [`RUP_SR_W-1:0] o_ctrl, q, seen;
  int n_fail = 0, checks = 0, cyc = 0;
  always #50 i_sys_clk = !i_sys_clk;
  always @(posedge i_sys_clk) if (++cyc > 2000) begin
    n_fail++;
    close_out();
  end
  rup_user i_user (.i_sys_clk(i_sys_clk), .i_kick(kick), .i_req(req),
    .o_watchdog_kick_n(kick_n), .o_reconfig_req(rq));
  rup_port i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_shift(i_shift),
    .i_capture(i_capture), .i_serial_in(i_serial_in), .i_watchdog_kick_n(kick_n),
    .i_reconfig_req(rq), .i_config_mode(2'h2), .i_forced_img0(forced), .i_img0_loaded(loaded),
    .o_serial_out(o_serial_out), .o_watchdog_reset(o_watchdog_reset),
    .o_reconfig_start(o_reconfig_start), .o_next_image(o_next_image), .o_ctrl(o_ctrl));
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // shift a word in msb first, collecting the old contents, then load
  task automatic xfer(logic [31:0] d, logic cap);
    for (int i = 31; i >= 0; i--) begin
      @(posedge i_sys_clk) i_shift <= 1'b1;
      i_serial_in <= d[i];
      @(negedge i_sys_clk) q[i] = o_serial_out;
    end
    @(posedge i_sys_clk) i_shift <= 1'b0;
    i_capture <= cap;
    @(posedge i_sys_clk) i_capture <= 1'b1;
    repeat (2) @(negedge i_sys_clk);
  endtask
  task automatic t_load;
    xfer(32'h00000003, 1'b0);
    chk("status", 32'h0000000e, q);
    chk("ctrl", 32'h00000003, o_ctrl);
    chk("next image", 32'h1, o_next_image);
    xfer(32'hc3a50001, 1'b0);
    chk("ctrl", 32'hc3a50001, o_ctrl);
    chk("next image", 32'h0, o_next_image);
    @(posedge i_sys_clk) loaded <= 1'b0;
    xfer(32'h00000003, 1'b0);
    chk("status", 32'h00000006, q);
    chk("next image", 32'h0, o_next_image);
    @(posedge i_sys_clk) {forced, loaded} <= 2'h1;
    xfer(32'hffffffff, 1'b1);
    chk("status", 32'h0000000a, q);
    chk("ctrl held", 32'h00000003, o_ctrl);
    chk("next image", 32'h0, o_next_image);
  endtask
  // reset in mid-run clears the control word and the image select
  task automatic t_reset;
    @(posedge i_sys_clk) i_rst <= 1'b1;
    @(negedge i_sys_clk) chk("ctrl reset", 32'h0, o_ctrl);
    chk("next image reset", 32'h0, o_next_image);
    @(posedge i_sys_clk) i_rst <= 1'b0;
  endtask
  task automatic act(bit w);
    seen = 0;
    @(posedge i_sys_clk) if (w) kick <= 1'b1; else req <= 1'b1;
    @(posedge i_sys_clk) kick <= 1'b0;
    repeat (8) @(negedge i_sys_clk) seen += w ? o_watchdog_reset : o_reconfig_start;
    @(posedge i_sys_clk) req <= 1'b0;
    chk(w ? "watchdog reset" : "reconfig start", 32'h1, seen);
  endtask
  task automatic close_out;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_load();
    t_reset();
    act(1'b1);
    act(1'b0);
    close_out();
  end
endmodule
